// ==== spsm_top.sv ====
module spsm_top (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        ctrl_wr,
  input  wire spsm_pkg::spsm_ctrl_s        ctrl_wdata,
  output spsm_pkg::spsm_ctrl_s             ctrl_q,
  output spsm_pkg::spsm_stat_s             stat_q,
  input  wire logic                        done_clr,
  input  wire logic                        fault_clr,
  input  wire logic                        ovr_clr,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  input  wire logic [spsm_pkg::BYTE_W-1:0] tx_data,
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  output logic [spsm_pkg::BYTE_W-1:0]      rx_data,
  input  wire logic                        sck_in,
  output logic                             sck_out,
  output logic                             sck_oe,
  input  wire logic                        mosi_in,
  output logic                             mosi_out,
  output logic                             mosi_oe,
  input  wire logic                        miso_in,
  output logic                             miso_out,
  output logic                             miso_oe,
  input  wire logic                        nss_in,
  output logic                             nss_out,
  output logic                             nss_oe,
  output logic                             nss_pin_routed
);
  import spsm_pkg::*;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction : rose

  // ----------------------------------------------------------------
  // pin synchronisers; third stage only feeds edge detection
  // ----------------------------------------------------------------
  logic sck_s1, sck_s2, sck_s3;
  logic nss_s1, nss_s2, nss_s3;
  logic mosi_s1, mosi_s2;
  logic miso_s1, miso_s2;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      nss_s1  <= 1'b1;
      nss_s2  <= 1'b1;
      nss_s3  <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      sck_s1  <= sck_in;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      nss_s1  <= nss_in;
      nss_s2  <= nss_s1;
      nss_s3  <= nss_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spsm_ctrl_s        ctrl_reg,  ctrl_next;
  logic              done_reg,  done_next;
  logic              fault_reg, fault_next;
  logic              ovr_reg,   ovr_next;
  logic [BYTE_W-1:0] sr_reg,    sr_next;
  logic              srf_reg,   srf_next;
  logic [CNT_W-1:0]  cnt_reg,   cnt_next;
  logic              pend_reg,  pend_next;
  logic              bit_reg,   bit_next;
  logic [BYTE_W-1:0] hold_reg,  hold_next;
  logic              holdf_reg, holdf_next;
  spsm_state_e       state_reg, state_next;
  logic [DIV_W-1:0]  div_reg,   div_next;
  logic              sck_reg,   sck_next;
  logic              push_reg,  push_next;
  logic [BYTE_W-1:0] pdat_reg,  pdat_next;

  logic en, mst, sel, fault, rise_ev, fall_ev, in_bit, buf_ready;

  always_comb begin
    ctrl_next  = ctrl_reg;
    done_next  = done_reg & ~done_clr;
    fault_next = fault_reg & ~fault_clr;
    ovr_next   = ovr_reg & ~ovr_clr;
    sr_next    = sr_reg;
    srf_next   = srf_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    bit_next   = bit_reg;
    hold_next  = hold_reg;
    holdf_next = holdf_reg;
    state_next = state_reg;
    div_next   = div_reg;
    sck_next   = sck_reg;
    push_next  = 1'b0;
    pdat_next  = pdat_reg;
    rise_ev    = 1'b0;
    fall_ev    = 1'b0;

    en  = ctrl_reg.port_enable_bit;
    mst = en & ctrl_reg.master_enable_bit;                         // [R14]
    // 1x as slave is a misuse; treated as never selected
    sel = (ctrl_reg.select_mode_field == SEL_3WIRE) |              // [R7]
          ((ctrl_reg.select_mode_field == SEL_4W_IN) & ~nss_s2);   // [R8]
    fault = mst & (ctrl_reg.select_mode_field == SEL_4W_IN) &
            fell(nss_s3, nss_s2);                                  // [R9]
    in_bit = mst ? miso_s2 : mosi_s2;

    if (ctrl_wr) begin
      ctrl_next = ctrl_wdata;
    end

    // transmit holding register, one deep
    if (tx_valid && !holdf_reg) begin
      hold_next  = tx_data;
      holdf_next = 1'b1;
    end
    if (holdf_reg && !srf_reg && cnt_reg == 4'h0 && !pend_reg &&
        state_reg == SPSM_IDLE) begin
      sr_next    = hold_reg;
      srf_next   = 1'b1;
      holdf_next = 1'b0;
    end

    // edge source: own divider as master, synced pin as slave
    if (mst) begin                                                 // [R5]
      if (state_reg == SPSM_IDLE) begin
        // stall start while the receive side has no room
        if (srf_reg && buf_ready) begin
          state_next = SPSM_RUN;
          div_next   = DIV_RELOAD;
        end
      end else if (div_reg == DIV_ZERO) begin
        div_next = DIV_RELOAD;
        sck_next = ~sck_reg;
        rise_ev  = ~sck_reg;
        fall_ev  = sck_reg;
      end else begin
        div_next = div_reg - 4'h1;
      end
    end else if (en && sel) begin                                  // [R6]
      rise_ev = rose(sck_s3, sck_s2);                              // [R5]
      fall_ev = fell(sck_s3, sck_s2);
    end

    if (rise_ev) begin
      bit_next = in_bit;
      if (cnt_reg == LAST_BIT) begin                               // [R17]
        pdat_next = {sr_reg[BYTE_W-2:0], in_bit};                  // [R2]
        if (buf_ready) begin
          push_next = 1'b1;
        end else begin
          ovr_next = 1'b1;
        end
        done_next = 1'b1;                                          // [R16]
        cnt_next  = 4'h0;
        pend_next = 1'b0;
        srf_next  = 1'b0;
      end else begin
        cnt_next  = cnt_reg + 4'h1;
        pend_next = 1'b1;
      end
    end
    if (fall_ev) begin
      if (pend_reg) begin
        sr_next   = {sr_reg[BYTE_W-2:0], bit_reg};                 // [R18]
        pend_next = 1'b0;
      end else if (cnt_reg == 4'h0) begin
        state_next = SPSM_IDLE;
      end
    end

    // 4-wire slave: select fall restarts the byte
    if (!mst && ctrl_reg.select_mode_field == SEL_4W_IN &&
        fell(nss_s3, nss_s2)) begin
      cnt_next  = 4'h0;
      pend_next = 1'b0;
    end

    // disabling is the only way to resync a 3-wire slave
    if (!en || (ctrl_reg.master_enable_bit && !mst)) begin
      cnt_next   = 4'h0;
      pend_next  = 1'b0;
      state_next = SPSM_IDLE;
      sck_next   = 1'b0;
    end

    // hardware fault beats a software write in the same cycle
    if (fault) begin                                               // [R15]
      ctrl_next.master_enable_bit = 1'b0;
      ctrl_next.port_enable_bit   = 1'b0;
      fault_next = 1'b1;
      state_next = SPSM_IDLE;
      sck_next   = 1'b0;
      cnt_next   = 4'h0;
      pend_next  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin                                                // [R19]
      ctrl_reg  <= CTRL_RST;
      done_reg  <= 1'b0;
      fault_reg <= 1'b0;
      ovr_reg   <= 1'b0;
      sr_reg    <= 8'h00;
      srf_reg   <= 1'b0;
      cnt_reg   <= 4'h0;
      pend_reg  <= 1'b0;
      bit_reg   <= 1'b0;
      hold_reg  <= 8'h00;
      holdf_reg <= 1'b0;
      state_reg <= SPSM_IDLE;
      div_reg   <= DIV_ZERO;
      sck_reg   <= 1'b0;
      push_reg  <= 1'b0;
      pdat_reg  <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      done_reg  <= done_next;
      fault_reg <= fault_next;
      ovr_reg   <= ovr_next;
      sr_reg    <= sr_next;
      srf_reg   <= srf_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      bit_reg   <= bit_next;
      hold_reg  <= hold_next;
      holdf_reg <= holdf_next;
      state_reg <= state_next;
      div_reg   <= div_next;
      sck_reg   <= sck_next;
      push_reg  <= push_next;
      pdat_reg  <= pdat_next;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer: slave cannot stall, so a full buffer drops
  // ----------------------------------------------------------------
  spsm_buf2 u_rxbuf (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (push_reg),
    .in_ready  (buf_ready),
    .in_data   (pdat_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ----------------------------------------------------------------
  // outputs and pin drive
  // ----------------------------------------------------------------
  assign tx_ready = ~holdf_reg;
  assign ctrl_q   = ctrl_reg;
  assign stat_q   = '{
    transfer_done_flag: done_reg,
    mode_fault_flag:    fault_reg,
    rx_overrun_flag:    ovr_reg,
    busy:               (state_reg == SPSM_RUN) | pend_reg |
                        (cnt_reg != 4'h0)
  };

  assign sck_out  = sck_reg;
  assign sck_oe   = mst;                                           // [R5]
  assign mosi_out = sr_reg[BYTE_W-1];                              // [R1]
  assign mosi_oe  = mst;                                           // [R1]
  assign miso_out = sr_reg[BYTE_W-1];                              // [R4]
  assign miso_oe  = en & ~ctrl_reg.master_enable_bit & sel;        // [R3]
  assign nss_out  = ctrl_reg.select_mode_field[SEL_LO];            // [R10]
  assign nss_oe   = ctrl_reg.select_mode_field[SEL_HI];            // [R10]
  assign nss_pin_routed = (ctrl_reg.select_mode_field != SEL_3WIRE); // [R12]

endmodule : spsm_top

// ==== spsm_pkg.sv ====
// Overview of operation
// [R1] master drives master-out from shift MSB
// [R2] bytes travel most significant bit first
// [R3] slave-out floats disabled or unselected
// [R4] 3-wire slave always drives slave-out
// [R5] master makes clock, slave receives it
// [R6] unselected 4-wire slave ignores clock edges
// [R7] mode 00: 3-wire, slave always selected
// [R8] mode 01: select input, low selects
// [R9] mode 01 master: select fall disables
// [R10] mode 1x: select output equals low bit
// [R11] software uses mode 1x only as master
// [R12] select pin routed except in 3-wire
// [R13] 3-wire slave must be alone on bus
// [R14] master-enable set means master, else slave
// [R15] mode fault clears enables, sets flag
// [R16] every finished byte sets done flag
// [R17] slave counts 8 edges, stores byte
// [R18] full-duplex: bits in low, out high
// [R19] reset restores defaults, slave-out floats
package spsm_pkg;

  // ----------------------------------------------------------------
  // field layout and encodings
  // ----------------------------------------------------------------
  localparam int          BYTE_W     = 8;
  localparam int          CNT_W      = 4;
  localparam logic [1:0]  SEL_3WIRE  = 2'h0;
  localparam logic [1:0]  SEL_4W_IN  = 2'h1;
  localparam int          SEL_HI     = 1;
  localparam int          SEL_LO     = 0;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;

  typedef struct packed {
    logic [1:0] select_mode_field;
    logic       master_enable_bit;
    logic       port_enable_bit;
  } spsm_ctrl_s;

  // multi-master select mode, port off, slave role after reset
  localparam spsm_ctrl_s CTRL_RST = '{
    select_mode_field: SEL_4W_IN,
    master_enable_bit: 1'b0,
    port_enable_bit:   1'b0
  };

  typedef struct packed {
    logic transfer_done_flag;
    logic mode_fault_flag;
    logic rx_overrun_flag;
    logic busy;
  } spsm_stat_s;

  typedef enum logic {
    SPSM_IDLE,
    SPSM_RUN
  } spsm_state_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W       = 4;
  localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(SCK_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO   = 4'h0;

endpackage : spsm_pkg

// ==== spsm_buf2.sv ====
module spsm_buf2 (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  input  wire logic [spsm_pkg::BYTE_W-1:0] in_data,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [spsm_pkg::BYTE_W-1:0]    out_data
);
  import spsm_pkg::*;

  // ----------------------------------------------------------------
  // two entries: head feeds the output straight from a flop
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] head_reg, head_next;
  logic [BYTE_W-1:0] tail_reg, tail_next;
  logic [1:0]        cnt_reg,  cnt_next;
  logic              push;
  logic              pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = head_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    head_next = head_reg;
    tail_next = tail_reg;
    cnt_next  = cnt_reg;
    case (cnt_reg)
      2'h0: begin
        if (push) begin
          head_next = in_data;
          cnt_next  = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          head_next = in_data;
        end else if (push) begin
          tail_next = in_data;
          cnt_next  = 2'h2;
        end else if (pop) begin
          cnt_next  = 2'h0;
        end
      end
      default: begin
        if (pop) begin
          head_next = tail_reg;
          cnt_next  = 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      head_reg <= 8'h00;
      tail_reg <= 8'h00;
      cnt_reg  <= 2'h0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      cnt_reg  <= cnt_next;
    end
  end

endmodule : spsm_buf2

// ==== spsm_top_sva.sv ====
// ----------------------------------------------------------------
// port behaviour checks
// ----------------------------------------------------------------
module spsm_top_sva (
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire spsm_pkg::spsm_ctrl_s ctrl_q,
  input wire spsm_pkg::spsm_stat_s stat_q,
  input wire logic                 sck_oe,
  input wire logic                 mosi_oe,
  input wire logic                 miso_oe,
  input wire logic                 nss_in,
  input wire logic                 nss_out,
  input wire logic                 nss_oe,
  input wire logic                 nss_pin_routed
);
  import spsm_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic       en;
  logic       mst;
  logic [1:0] md;
  assign en  = ctrl_q.port_enable_bit;
  assign mst = ctrl_q.master_enable_bit;
  assign md  = ctrl_q.select_mode_field;
  property p_rst;
    $fell(srst) |-> ctrl_q == CTRL_RST && !miso_oe
      && !stat_q.transfer_done_flag && !stat_q.mode_fault_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_off;
    !en |-> !miso_oe;
  endproperty
  a_off: assert property (p_off) else $error("slave-out driven");
  property p_mst;
    en && mst |-> sck_oe && mosi_oe && !miso_oe;
  endproperty
  a_mst: assert property (p_mst) else $error("master oe");
  property p_slv;
    en && !mst |-> !sck_oe && !mosi_oe;
  endproperty
  a_slv: assert property (p_slv) else $error("slave oe");
  property p_3w;
    en && !mst && md == SEL_3WIRE |-> miso_oe;
  endproperty
  a_3w: assert property (p_3w) else $error("3-wire float");
  property p_sel;
    nss_in [*4] ##0 (en && !mst && md == SEL_4W_IN) |-> !miso_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("unselected drive");
  property p_nss;
    md[SEL_HI] && $stable(ctrl_q) |-> nss_oe && nss_out == md[SEL_LO];
  endproperty
  a_nss: assert property (p_nss) else $error("select output");
  property p_nssin;
    !md[SEL_HI] |-> !nss_oe;
  endproperty
  a_nssin: assert property (p_nssin) else $error("select dir");
  property p_rout;
    nss_pin_routed == (md != SEL_3WIRE);
  endproperty
  a_rout: assert property (p_rout) else $error("select routing");
  // sync delay of the select pin bounds the reaction time
  property p_flt;
    en && mst && md == SEL_4W_IN && $fell(nss_in) |-> ##[1:6]
      (!en && !mst && stat_q.mode_fault_flag);
  endproperty
  a_flt: assert property (p_flt) else $error("mode fault");
endmodule : spsm_top_sva

bind spsm_top spsm_top_sva u_spsm_top_sva (
  .mclk(mclk), .srst(srst), .ctrl_q(ctrl_q), .stat_q(stat_q),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe),
  .nss_pin_routed(nss_pin_routed)
);

// ==== spsm_peer.sv ====
// ----------------------------------------------------------------
// far-side peer: slave for device master, master for device slave
// ----------------------------------------------------------------
module spsm_peer (
  input  wire logic sck_line,
  input  wire logic mosi_line,
  input  wire logic miso_line,
  output logic      m_sck,
  output logic      m_mosi,
  output logic      m_miso,
  output logic      m_nss
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       slv;
  logic [7:0] s_tx;
  logic [7:0] s_rx;
  initial begin
    m_sck  = 1'b0;
    m_mosi = 1'b0;
    m_miso = 1'b0;
    m_nss  = 1'b1;
    slv    = 1'b0;
  end
  always @(posedge sck_line) begin
    if (slv) s_rx = {s_rx[6:0], mosi_line};
  end
  always @(negedge sck_line) begin
    if (slv) begin
      s_tx   = {s_tx[6:0], 1'b0};
      m_miso = s_tx[7];
    end
  end
  task slave_on(input logic [7:0] b);
    s_tx   = b;
    m_miso = b[7];
    slv    = 1'b1;
  endtask : slave_on
  // released line shows the inverse, never a stale bit
  task slave_off;
    slv    = 1'b0;
    m_miso = ~m_miso;
  endtask : slave_off
  task set_nss(input logic v);
    m_nss = v;
  endtask : set_nss
  // clock stands still between frames; 160 ns period
  task mxfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    m_nss = ~sel;
    #163;
    for (int i = 7; i >= 0; i--) begin
      m_mosi = tx[i];
      #80 m_sck = 1'b1;
      #70 rx[i] = miso_line;
      #10 m_sck = 1'b0;
    end
    #160 m_nss = 1'b1;
    m_mosi = ~m_mosi;
  endtask : mxfer
endmodule : spsm_peer

// ==== spsm_top_tb.sv ====
// ----------------------------------------------------------------
// testbench
// ----------------------------------------------------------------
module spsm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spsm_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, ctrl_wr = 1'b0, rx_ready = 1'b0;
  logic done_clr = 1'b0, fault_clr = 1'b0, ovr_clr = 1'b0, tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data, got;
  spsm_ctrl_s ctrl_wdata = CTRL_RST, ctrl_q;
  spsm_stat_s stat_q;
  logic tx_ready, rx_valid, sck_out, sck_oe, mosi_out, mosi_oe, miso_out;
  logic miso_oe, nss_out, nss_oe, nss_pin_routed, m_sck, m_mosi, m_miso;
  logic m_nss, sck_in, mosi_in, miso_in, nss_in;
  int   error_cnt = 0, compares = 0;
  always #10 mclk = ~mclk;
  assign sck_in  = sck_oe ? sck_out : m_sck;
  assign mosi_in = mosi_oe ? mosi_out : m_mosi;
  assign miso_in = miso_oe ? miso_out : m_miso;
  assign nss_in  = nss_oe ? nss_out : m_nss;
  spsm_top u_spsm_top (.mclk(mclk), .srst(srst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_q(ctrl_q), .stat_q(stat_q),
    .done_clr(done_clr), .fault_clr(fault_clr), .ovr_clr(ovr_clr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe),
    .nss_pin_routed(nss_pin_routed));
  spsm_peer u_spsm_peer (.sck_line(sck_in), .mosi_line(mosi_in),
    .miso_line(miso_in), .m_sck(m_sck), .m_mosi(m_mosi),
    .m_miso(m_miso), .m_nss(m_nss));
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function logic sig(input int k);
    case (k)
      0: return tx_ready;
      1: return rx_valid;
      2: return stat_q.transfer_done_flag;
      default: return stat_q.mode_fault_flag;
    endcase
  endfunction : sig
  task wait_for(input int k);
    int n;
    n = 0;
    while (sig(k) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        $display("[ERR] %0t timeout", $time);
        wrap_up;
      end
    end
  endtask : wait_for
  task wr_ctrl(input logic [1:0] md, input logic ms, input logic en);
    @(negedge mclk);
    ctrl_wr    = 1'b1;
    ctrl_wdata = {md, ms, en};
    @(negedge mclk);
    ctrl_wr = 1'b0;
    @(negedge mclk);
  endtask : wr_ctrl
  task clr_flags;
    @(negedge mclk);
    {done_clr, fault_clr, ovr_clr} = 3'h7;
    @(negedge mclk);
    {done_clr, fault_clr, ovr_clr} = 3'h0;
    @(negedge mclk);
    chk(8'(stat_q), 8'h00);
  endtask : clr_flags
  task send_tx(input logic [7:0] b);
    @(negedge mclk);
    wait_for(0);
    tx_valid = 1'b1;
    tx_data  = b;
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask : send_tx
  task get_rx(input logic [7:0] e);
    wait_for(1);
    chk(rx_data, e);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
  endtask : get_rx
  task t_reset;
    srst = 1'b1;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    chk(8'({ctrl_q, miso_oe, tx_ready}), 8'({CTRL_RST, 2'b01}));
    chk(8'(stat_q), 8'h00);
  endtask : t_reset
  // select output mode only as master
  task t_master;
    wr_ctrl(2'h2, 1'b1, 1'b1);
    chk(8'({nss_oe, nss_out}), 8'h02);
    chk(8'({sck_oe, mosi_oe, miso_oe}), 8'h06);
    u_spsm_peer.slave_on(8'h3c);
    send_tx(8'ha5);
    wait_for(2);
    chk(8'(stat_q.busy), 8'h01);
    get_rx(8'h3c);
    chk(u_spsm_peer.s_rx, 8'ha5);
    u_spsm_peer.slave_off;
    wr_ctrl(2'h3, 1'b1, 1'b1);
    chk(8'({nss_oe, nss_out}), 8'h03);
    clr_flags;
  endtask : t_master
  task t_slave4;
    wr_ctrl(2'h1, 1'b0, 1'b1);
    send_tx(8'h5a);
    u_spsm_peer.mxfer(8'hff, 1'b0, got);
    repeat (4) @(negedge mclk);
    chk(8'({stat_q.transfer_done_flag, miso_oe}), 8'h00);
    u_spsm_peer.mxfer(8'h96, 1'b1, got);
    chk(got, 8'h5a);
    get_rx(8'h96);
    clr_flags;
  endtask : t_slave4
  // receiver stalls: two words held, third lost
  task t_buffer;
    for (int i = 0; i < 3; i++) begin
      u_spsm_peer.mxfer(8'h10 + 8'(i), 1'b1, got);
      // let the select pin rise and be seen between bytes
      repeat (4) @(negedge mclk);
    end
    repeat (8) @(negedge mclk);
    chk(8'(stat_q.rx_overrun_flag), 8'h01);
    get_rx(8'h10);
    get_rx(8'h11);
    @(negedge mclk);
    chk(8'(rx_valid), 8'h00);
    clr_flags;
  endtask : t_buffer
  // device is the only slave on the bus; peer acts as master
  task t_slave3;
    wr_ctrl(2'h0, 1'b0, 1'b1);
    chk(8'({miso_oe, nss_pin_routed}), 8'h02);
    send_tx(8'hc3);
    u_spsm_peer.mxfer(8'h81, 1'b0, got);
    chk(got, 8'hc3);
    get_rx(8'h81);
    clr_flags;
  endtask : t_slave3
  task t_fault;
    wr_ctrl(2'h1, 1'b1, 1'b1);
    chk(8'({sck_oe, mosi_oe, nss_pin_routed}), 8'h07);
    u_spsm_peer.set_nss(1'b0);
    wait_for(3);
    @(negedge mclk);
    chk(8'({ctrl_q.master_enable_bit, ctrl_q.port_enable_bit}), 8'h00);
    u_spsm_peer.set_nss(1'b1);
    clr_flags;
  endtask : t_fault
  initial begin
    t_reset;
    t_master;
    t_slave4;
    t_buffer;
    t_slave3;
    t_fault;
    t_reset;
    wrap_up;
  end
endmodule : spsm_top_tb
